// ### hw/hdpm_defs.svh
// Constants for the hub downstream port manager: offsets, reset values, timing.
// Assumes a 100 MHz device clock and an 8-bit register port.
// Behaviour
// - Low D+ with high D- that persists sets the port's connect bit.
// - High D+ with low D- that persists sets the port's connect bit.
// - Every connect bit set by hardware raises a hub interrupt pulse; a firmware write does not.
// - A connect is recorded only after non-SE0 lasts over 2.5 us.
// - SE0 lasting 2.0 to 2.5 us clears the connect bit and interrupts.
// - Connect register has bits for ports one to seven; bit 7 reads zero.
// - Device reset and bus reset clear connect status, then hardware updates it.
// - Speed register clears on device or bus reset; firmware sets it later.
// - A set enable bit opens the port for traffic both ways.
// - Enabled unsuspended ports get upstream traffic; their traffic repeats unless babble.
// - Full-speed upstream traffic never goes to a low-speed port.
// - Enable written mid-packet takes effect at packet end; at idle at once.
// - Connect and disconnect interrupt even while suspended or disabled.
// - Device reset and bus reset clear the enable register.
// - Babble on a port clears that port's enable bit in hardware.
// - Babble is non-idle traffic or open connectivity at EOF2.
// - Both lines low is the no-connect SE0 state.
// - The hub generates an end-of-packet at EOF1.
`ifndef HDPM_DEFS_SVH
`define HDPM_DEFS_SVH

`define HDPM_ADDR_CONNECT 8'h48
`define HDPM_ADDR_ENABLE 8'h49
`define HDPM_ADDR_SPEED 8'h4a
`define HDPM_RESET_VAL 8'h00
`define HDPM_PORT_MASK 8'h7f
`define HDPM_CLK_MHZ 100
// Times in nanoseconds.
`define HDPM_CONN_NS 2500
`define HDPM_DISC_MIN_NS 2000
// Connect needs more than 2.5 us: one cycle past the rounded-up count.
`define HDPM_CONN_CYC ((`HDPM_CONN_NS * `HDPM_CLK_MHZ + 999) / 1000 + 1)
// Disconnect qualifies at 2.0 us, inside the 2.0 to 2.5 us window.
`define HDPM_DISC_CYC ((`HDPM_DISC_MIN_NS * `HDPM_CLK_MHZ + 999) / 1000)

`endif

// ### hw/hdpm_pkg.sv
// Types for the hub downstream port manager.
// Assumes nothing beyond the constants header.
package hdpm_pkg;
  typedef logic [6:0] hdpm_ports_t;
  typedef logic [7:0] hdpm_byte_t;
  typedef logic [8:0] hdpm_cnt_t;
  typedef enum logic [1:0] {
    HDPM_LS_SE0 = 2'b00,
    HDPM_LS_K = 2'b01,
    HDPM_LS_J = 2'b10,
    HDPM_LS_SE1 = 2'b11
  } hdpm_line_t;
endpackage

// ### hw/hdpm_port_manager.sv
// Downstream port manager: connect timing, status, enable, speed, babble, repeat gating.
// Assumes line pins are asynchronous; frame markers and packet activity come from the
// repeater on the same clock.
`include "hdpm_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module hdpm_port_manager (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic bus_reset_i,
  input wire logic suspend_i,
  input wire logic [7:0] addr_i,
  input wire hdpm_pkg::hdpm_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output hdpm_pkg::hdpm_byte_t rdata_o,
  input wire hdpm_pkg::hdpm_ports_t dp_i,
  input wire hdpm_pkg::hdpm_ports_t dm_i,
  input wire logic up_pkt_active_i,
  input wire logic up_full_speed_i,
  input wire hdpm_pkg::hdpm_ports_t dn_active_i,
  input wire logic eof1_i,
  input wire logic eof2_i,
  output logic hub_irq_o,
  output logic eop_gen_o,
  output hdpm_pkg::hdpm_ports_t fwd_down_o,
  output hdpm_pkg::hdpm_ports_t fwd_up_o,
  output hdpm_pkg::hdpm_ports_t babble_o
);
  import hdpm_pkg::*;

  localparam hdpm_cnt_t CONN_CYC = hdpm_cnt_t'(`HDPM_CONN_CYC);
  localparam hdpm_cnt_t DISC_CYC = hdpm_cnt_t'(`HDPM_DISC_CYC);

  function automatic logic hdpm_sel(input logic [7:0] a, input logic [7:0] off);
    hdpm_sel = (a == off);
  endfunction

  // ==========================================================================
  // Line synchronisers
  // ==========================================================================
  hdpm_ports_t dp_s1_q, dp_s2_q, dm_s1_q, dm_s2_q;
  hdpm_ports_t dp_s1_d, dp_s2_d, dm_s1_d, dm_s2_d;

  always_comb begin
    dp_s1_d = dp_i;
    dm_s1_d = dm_i;
    dp_s2_d = dp_s1_q;
    dm_s2_d = dm_s1_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_s1_q <= '0;
      dp_s2_q <= '0;
      dm_s1_q <= '0;
      dm_s2_q <= '0;
    end else if (clk_en_i) begin
      dp_s1_q <= dp_s1_d;
      dp_s2_q <= dp_s2_d;
      dm_s1_q <= dm_s1_d;
      dm_s2_q <= dm_s2_d;
    end
  end

  // ==========================================================================
  // Per-port line-state timers and connect tracking
  // ==========================================================================
  hdpm_line_t line_q [7];
  hdpm_line_t line_d [7];
  hdpm_cnt_t cnt_q [7];
  hdpm_cnt_t cnt_d [7];
  hdpm_ports_t conn_q, conn_d, en_q, en_d, pend_q, pend_d, spd_q, spd_d;
  hdpm_ports_t conn_set, conn_clr, babble_d, babble_q;
  logic irq_d, irq_q, eop_d, eop_q;
  hdpm_byte_t rdata_d, rdata_q;
  logic wr_conn, wr_en, wr_spd;

  always_comb begin
    wr_conn = wr_i && hdpm_sel(addr_i, `HDPM_ADDR_CONNECT);
    wr_en = wr_i && hdpm_sel(addr_i, `HDPM_ADDR_ENABLE);
    wr_spd = wr_i && hdpm_sel(addr_i, `HDPM_ADDR_SPEED);
    for (int p = 0; p < 7; p++) begin
      line_d[p] = hdpm_line_t'({dp_s2_q[p], dm_s2_q[p]});
      // Count restarts whenever the sampled state changes; saturates after qualifying.
      if (line_d[p] != line_q[p]) begin
        cnt_d[p] = '0;
      end else if (cnt_q[p] != CONN_CYC) begin
        cnt_d[p] = cnt_q[p] + 9'd1;
      end else begin
        cnt_d[p] = cnt_q[p];
      end
      // Both low from the pull-downs is no-connect.
      conn_clr[p] = conn_q[p] && (line_q[p] == HDPM_LS_SE0)
                    && (cnt_q[p] == DISC_CYC);
      // K is low-speed attach, J full-speed attach; SE1 never counts as attach.
      conn_set[p] = !conn_q[p] && ((line_q[p] == HDPM_LS_K) || (line_q[p] == HDPM_LS_J))
                    && (cnt_q[p] == CONN_CYC);
    end
    conn_d = conn_q;
    if (wr_conn) begin
      conn_d = wdata_i[6:0];
    end
    // Hardware events win over a same-cycle firmware write.
    conn_d = (conn_d | conn_set) & ~conn_clr;
    // Interrupt regardless of suspend or enable state.
    irq_d = |(conn_set | conn_clr);
    if (bus_reset_i) begin
      conn_d = '0;
      // Restart every line timer so that connect status is rebuilt from the live lines.
      // Without this a saturated timer would re-set the bit in the very next cycle.
      for (int p = 0; p < 7; p++) begin
        cnt_d[p] = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int p = 0; p < 7; p++) begin
        line_q[p] <= HDPM_LS_SE0;
        cnt_q[p] <= '0;
      end
      conn_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en_i) begin
      line_q <= line_d;
      cnt_q <= cnt_d;
      conn_q <= conn_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================================
  // Enable, speed, babble and deferred enable
  // ==========================================================================
  always_comb begin
    spd_d = spd_q;
    if (wr_spd) begin
      spd_d = wdata_i[6:0];
    end
    if (bus_reset_i) begin
      spd_d = '0;
    end
    // At EOF2, any enabled port still talking or holding the path open babbles.
    babble_d = eof2_i ? (en_q & dn_active_i) : '0;
    en_d = en_q;
    pend_d = pend_q;
    if (wr_en) begin
      // Enables apply at once when idle, else wait for the packet to end.
      en_d = up_pkt_active_i ? (wdata_i[6:0] & en_q) : wdata_i[6:0];
      pend_d = up_pkt_active_i ? (wdata_i[6:0] & ~en_q) : '0;
    end else if (!up_pkt_active_i && (pend_q != '0)) begin
      en_d = en_q | pend_q;
      pend_d = '0;
    end
    en_d = en_d & ~babble_d;
    pend_d = pend_d & ~babble_d;
    if (bus_reset_i) begin
      en_d = '0;
      pend_d = '0;
    end
    eop_d = eof1_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spd_q <= '0;
      en_q <= '0;
      pend_q <= '0;
      babble_q <= '0;
      eop_q <= 1'b0;
    end else if (clk_en_i) begin
      spd_q <= spd_d;
      en_q <= en_d;
      pend_q <= pend_d;
      babble_q <= babble_d;
      eop_q <= eop_d;
    end
  end

  // ==========================================================================
  // Repeat gating
  // ==========================================================================
  always_comb begin
    fwd_down_o = suspend_i ? '0 : (en_q & ~(spd_q & {7{up_full_speed_i}}));
    fwd_up_o = suspend_i ? '0 : (en_q & ~babble_d);
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always_comb begin
    rdata_d = `HDPM_RESET_VAL;
    if (rd_i) begin
      case (addr_i)
        `HDPM_ADDR_CONNECT: rdata_d = {1'b0, conn_q};
        `HDPM_ADDR_ENABLE: rdata_d = {1'b0, en_q};
        `HDPM_ADDR_SPEED: rdata_d = {1'b0, spd_q};
        default: rdata_d = `HDPM_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (clk_en_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign hub_irq_o = irq_q;
  assign eop_gen_o = eop_q;
  assign babble_o = babble_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  conn_irq_a: assert property (clk_en_i && |conn_set |=> hub_irq_o)
    else $error("connect without interrupt");
  disc_irq_a: assert property (clk_en_i && |conn_clr && !bus_reset_i |=> hub_irq_o)
    else $error("disconnect without interrupt");
  conn_time_a: assert property (clk_en_i && (conn_set[0]) |-> cnt_q[0] == CONN_CYC)
    else $error("connect qualified early");
  bit7_zero_a: assert property (rd_i |=> rdata_o[7] == 1'b0)
    else $error("reserved bit read nonzero");
  breset_clear_a: assert property (clk_en_i && bus_reset_i |=> en_q == '0 && spd_q == '0
                                   && conn_q == '0)
    else $error("bus reset left state");
  babble_dis_a: assert property (clk_en_i && eof2_i && |(en_q & dn_active_i)
                                 |=> (en_q & $past(en_q & dn_active_i)) == '0)
    else $error("babbling port stays enabled");
  ls_block_a: assert property (up_full_speed_i |-> (fwd_down_o & spd_q) == '0)
    else $error("full speed sent to low speed port");
  defer_en_a: assert property (clk_en_i && wr_en && up_pkt_active_i && !bus_reset_i
                               |=> (en_q & ~$past(en_q)) == '0)
    else $error("enable applied mid packet");
  eop_gen_a: assert property (clk_en_i && eof1_i |=> eop_gen_o)
    else $error("no eop at eof1");

  // Suspend closes both repeat directions whatever the enable bits say.
  susp_gate_a: assert property (suspend_i |-> fwd_down_o == '0 && fwd_up_o == '0)
    else $error("traffic repeated while suspended");

  // Only enabled ports may ever be opened in either direction.
  fwd_dn_en_a: assert property ((fwd_down_o & ~en_q) == '0)
    else $error("disabled port receives traffic");
  fwd_up_en_a: assert property ((fwd_up_o & ~en_q) == '0)
    else $error("disabled port repeated upstream");

  // With the bus idle a written enable mask lands on the next edge.
  idle_en_a: assert property (clk_en_i && wr_en && !up_pkt_active_i && !bus_reset_i
                              && !eof2_i |=> {1'b0, en_q} == ($past(wdata_i) & 8'h7f))
    else $error("idle enable not applied");

  // The speed mask takes what firmware wrote, without the reserved bit.
  spd_write_a: assert property (clk_en_i && wr_spd && !bus_reset_i
                                |=> {1'b0, spd_q} == ($past(wdata_i) & 8'h7f))
    else $error("speed write lost");

  // A disconnect is taken exactly when SE0 has lasted the minimum detect time.
  disc_time_a: assert property (clk_en_i && conn_clr[0] |-> cnt_q[0] == DISC_CYC)
    else $error("disconnect qualified at wrong time");

  // Bus reset restarts the line timers as well as the registers.
  breset_cnt_a: assert property (clk_en_i && bus_reset_i |=> cnt_q[0] == '0)
    else $error("line timer kept across bus reset");

  // The babble report names exactly the enabled ports active at EOF2.
  babble_out_a: assert property (clk_en_i && eof2_i
                                 |=> babble_o == ($past(en_q) & $past(dn_active_i)))
    else $error("babble report wrong");
  no_babble_a: assert property (clk_en_i && !eof2_i |=> babble_o == '0)
    else $error("babble outside eof2");

  // The reserved status bit never reads back as connected.
  conn_bit7_a: assert property (rd_i && addr_i == `HDPM_ADDR_CONNECT
                                |=> rdata_o[7] == 1'b0)
    else $error("reserved connect bit set");

  susp_irq_c: cover property (suspend_i && hub_irq_o);
  conn_c: cover property (|conn_set);
  disc_c: cover property (|conn_clr);
  defer_c: cover property (|pend_q ##1 pend_q == '0);
  babble_c: cover property (|babble_d);
endmodule

`default_nettype wire

// ### tb/hdpm_dev_model.sv
// Model of the devices on the downstream ports: one device per port or none.
// Assumes the bench chooses which ports hold a device and which are low speed.
`timescale 1ns/100ps
`default_nettype none
module hdpm_dev_model (
  input wire hdpm_pkg::hdpm_ports_t attach_i,
  input wire hdpm_pkg::hdpm_ports_t ls_i,
  output hdpm_pkg::hdpm_ports_t dp_o,
  output hdpm_pkg::hdpm_ports_t dm_o
);
  import hdpm_pkg::*;
  // =====================================
  // Line bias
  // An empty port is held at SE0 by the pull-downs, never left at the last level.
  assign dp_o = attach_i & ~ls_i;
  assign dm_o = attach_i & ls_i;
endmodule
`default_nettype wire

// ### tb/hub_downstream_port_manager_tb.sv
// Bench for the downstream port manager: register master, frame pulses, device model.
// Assumes a 100 MHz clock and the register map of the constants header.
`include "hdpm_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module hub_downstream_port_manager_tb;
  import hdpm_pkg::*;
  logic clk_i = 0, rst_n_i = 0, bus_rst = 0, susp = 0, wr = 0, rd = 0;
  logic pkt = 0, fs = 0, eof1 = 0, eof2 = 0, irq, eop;
  logic [7:0] addr = 8'h00;
  hdpm_byte_t wdata = 8'h00, rdata;
  hdpm_ports_t dp, dm, fwd_dn, fwd_up, babble, attach = 0, ls = 0, dn_act = 0;
  int miscompares = 0, n_compared = 0, cyc = 0;
  hdpm_port_manager i_hdpm_port_manager (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .bus_reset_i(bus_rst), .suspend_i(susp), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .dp_i(dp), .dm_i(dm), .up_pkt_active_i(pkt),
    .up_full_speed_i(fs), .dn_active_i(dn_act), .eof1_i(eof1), .eof2_i(eof2),
    .hub_irq_o(irq), .eop_gen_o(eop), .fwd_down_o(fwd_dn), .fwd_up_o(fwd_up),
    .babble_o(babble));
  hdpm_dev_model i_hdpm_dev_model (.attach_i(attach), .ls_i(ls), .dp_o(dp), .dm_o(dm));
  // =====================================
  // Helpers
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // A hang would otherwise never reach the verdict; the run needs under 3000 cycles.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(string nm, hdpm_byte_t exp, hdpm_byte_t got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(logic [7:0] a, hdpm_byte_t d);
    @(posedge clk_i);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rdchk(string nm, logic [7:0] a, hdpm_byte_t exp);
    @(posedge clk_i);
    rd <= 1'b1; addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask
  task automatic wait_irq(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      if (irq === 1'b1) break;
    end
    chk("irq", 8'h01, {7'h00, irq});
  endtask
  // =====================================
  // Scenarios
  task automatic t_regs();
    rdchk("conn", `HDPM_ADDR_CONNECT, 8'h00);
    rdchk("en", `HDPM_ADDR_ENABLE, 8'h00);
    rdchk("spd", `HDPM_ADDR_SPEED, 8'h00);
    rdchk("unmapped", 8'h4b, 8'h00);
  endtask
  task automatic t_connect();
    @(posedge clk_i);
    attach <= 7'h03; ls <= 7'h01;
    repeat (200) @(posedge clk_i);
    rdchk("conn early", `HDPM_ADDR_CONNECT, 8'h00);
    wait_irq(100);
    rdchk("conn", `HDPM_ADDR_CONNECT, 8'h03);
  endtask
  task automatic t_enable();
    wreg(`HDPM_ADDR_SPEED, 8'h81);
    rdchk("spd", `HDPM_ADDR_SPEED, 8'h01);
    fs <= 1'b1;
    wreg(`HDPM_ADDR_ENABLE, 8'h83);
    rdchk("en", `HDPM_ADDR_ENABLE, 8'h03);
    chk("fwd_dn fs", 8'h02, {1'b0, fwd_dn});
    chk("fwd_up", 8'h03, {1'b0, fwd_up});
    @(posedge clk_i);
    fs <= 1'b0; susp <= 1'b1;
    #1 chk("fwd_dn susp", 8'h00, {1'b0, fwd_dn});
    @(posedge clk_i);
    susp <= 1'b0;
    #1 chk("fwd_dn ls", 8'h03, {1'b0, fwd_dn});
  endtask
  task automatic t_defer();
    @(posedge clk_i);
    pkt <= 1'b1;
    wreg(`HDPM_ADDR_ENABLE, 8'h07);
    repeat (3) @(posedge clk_i);
    #1 chk("fwd_dn pkt", 8'h03, {1'b0, fwd_dn});
    @(posedge clk_i);
    pkt <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("fwd_dn idle", 8'h07, {1'b0, fwd_dn});
  endtask
  task automatic t_babble();
    @(posedge clk_i);
    dn_act <= 7'h02; eof2 <= 1'b1;
    @(posedge clk_i);
    eof2 <= 1'b0; dn_act <= 7'h00;
    #1 chk("babble", 8'h02, {1'b0, babble});
    rdchk("en babble", `HDPM_ADDR_ENABLE, 8'h05);
    @(posedge clk_i);
    eof1 <= 1'b1;
    @(posedge clk_i);
    eof1 <= 1'b0;
    #1 chk("eop", 8'h01, {7'h00, eop});
  endtask
  task automatic t_disc();
    @(posedge clk_i);
    susp <= 1'b1; attach <= 7'h02;
    repeat (150) @(posedge clk_i);
    rdchk("disc early", `HDPM_ADDR_CONNECT, 8'h03);
    wait_irq(100);
    rdchk("disc", `HDPM_ADDR_CONNECT, 8'h02);
    susp <= 1'b0;
  endtask
  task automatic t_busrst();
    @(posedge clk_i);
    bus_rst <= 1'b1;
    @(posedge clk_i);
    bus_rst <= 1'b0;
    t_regs();
    wait_irq(300);
    rdchk("conn again", `HDPM_ADDR_CONNECT, 8'h02);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_connect();
    t_enable();
    t_defer();
    t_babble();
    t_disc();
    t_busrst();
    conclude();
  end
endmodule
`default_nettype wire
